// ==== common/port_mux_pkg.sv ====
package port_mux_pkg;

   localparam int PORT_W = 8;

   // Register addresses on the special function register bus
   localparam logic [7:0] ADDR_P1_FUNC_EN = 8'h8E;
   localparam logic [7:0] ADDR_P1_ALT_SEL = 8'h8F;
   localparam logic [7:0] ADDR_P3_FUNC_EN = 8'h91;
   localparam logic [7:0] ADDR_P4_FUNC_EN = 8'h92;
   localparam logic [7:0] ADDR_P4_ALT_SEL = 8'h93;

   localparam logic [7:0] SEL_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // Register slots returned by the address decoder
   localparam logic [2:0] SLOT_P1_FUNC_EN = 3'h0;
   localparam logic [2:0] SLOT_P1_ALT_SEL = 3'h1;
   localparam logic [2:0] SLOT_P3_FUNC_EN = 3'h2;
   localparam logic [2:0] SLOT_P4_FUNC_EN = 3'h3;
   localparam logic [2:0] SLOT_P4_ALT_SEL = 3'h4;
   localparam logic [2:0] SLOT_NONE = 3'h7;

   // Pin positions of the alternate functions within a port
   localparam int TIMER2_LSB = 0;
   localparam int SERIAL_ONE_LSB = 2;
   localparam int SPI_LSB = 4;
   localparam int SERIAL_ZERO_LSB = 0;
   localparam int EXT_INT_LSB = 2;
   localparam int TIMERS_LSB = 4;
   localparam int I2C_LSB = 6;
   localparam int COUNTER_ZERO_LSB = 0;
   localparam int COUNTER_ONE_LSB = 4;

   // Clock limits kept by software while the serial bus pins are in use
   localparam int I2C_MIN_CLOCK_MHZ = 8;
   localparam int MAX_CLOCK_MHZ = 40;

   typedef enum logic [1:0] {
      MODE_GPIO = 2'b00,
      MODE_ALT1 = 2'b01,
      MODE_ALT2 = 2'b10
   } pin_mode_t;

   function automatic pin_mode_t pin_mode(input logic func_en,
                                          input logic alt_sel,
                                          input logic has_alt2);
      if (!func_en) begin
         return MODE_GPIO;
      end else if (alt_sel && has_alt2) begin
         return MODE_ALT2;
      end else begin
         return MODE_ALT1;
      end
   endfunction

   function automatic logic route(input pin_mode_t mode, input logic gpio,
                                  input logic alt1, input logic alt2);
      case (mode)
         MODE_GPIO: route = gpio;
         MODE_ALT1: route = alt1;
         MODE_ALT2: route = alt2;
         default: route = gpio;
      endcase
   endfunction

   function automatic logic [2:0] reg_slot(input logic [7:0] addr);
      case (addr)
         ADDR_P1_FUNC_EN: reg_slot = SLOT_P1_FUNC_EN;
         ADDR_P1_ALT_SEL: reg_slot = SLOT_P1_ALT_SEL;
         ADDR_P3_FUNC_EN: reg_slot = SLOT_P3_FUNC_EN;
         ADDR_P4_FUNC_EN: reg_slot = SLOT_P4_FUNC_EN;
         ADDR_P4_ALT_SEL: reg_slot = SLOT_P4_ALT_SEL;
         default: reg_slot = SLOT_NONE;
      endcase
   endfunction

endpackage

// ==== design/mcu_port_function_mux.sv ====
module mcu_port_function_mux
   import port_mux_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_clk_en,
   input wire logic [7:0] i_sfr_addr,
   input wire logic i_sfr_wr,
   input wire logic i_sfr_rd,
   input wire logic [7:0] i_sfr_wdata,
   output logic [7:0] o_sfr_rdata,
   output logic o_sfr_ack,
   input wire logic [port_mux_pkg::PORT_W-1:0] i_p1_pin,
   output logic [port_mux_pkg::PORT_W-1:0] o_p1_pin,
   output logic [port_mux_pkg::PORT_W-1:0] o_p1_pin_oe,
   input wire logic [port_mux_pkg::PORT_W-1:0] i_p3_pin,
   output logic [port_mux_pkg::PORT_W-1:0] o_p3_pin,
   output logic [port_mux_pkg::PORT_W-1:0] o_p3_pin_oe,
   input wire logic [port_mux_pkg::PORT_W-1:0] i_p4_pin,
   output logic [port_mux_pkg::PORT_W-1:0] o_p4_pin,
   output logic [port_mux_pkg::PORT_W-1:0] o_p4_pin_oe,
   input wire logic [port_mux_pkg::PORT_W-1:0] i_gpio1_out,
   input wire logic [port_mux_pkg::PORT_W-1:0] i_gpio1_oe,
   output logic [port_mux_pkg::PORT_W-1:0] o_gpio1_in,
   input wire logic [port_mux_pkg::PORT_W-1:0] i_gpio3_out,
   input wire logic [port_mux_pkg::PORT_W-1:0] i_gpio3_oe,
   output logic [port_mux_pkg::PORT_W-1:0] o_gpio3_in,
   input wire logic [port_mux_pkg::PORT_W-1:0] i_gpio4_out,
   input wire logic [port_mux_pkg::PORT_W-1:0] i_gpio4_oe,
   output logic [port_mux_pkg::PORT_W-1:0] o_gpio4_in,
   input wire logic [1:0] i_timer2_out,
   input wire logic [1:0] i_timer2_oe,
   output logic [1:0] o_timer2_in,
   input wire logic [1:0] i_serial_port_one_out,
   input wire logic [1:0] i_serial_port_one_oe,
   output logic [1:0] o_serial_port_one_in,
   input wire logic [3:0] i_spi_out,
   input wire logic [3:0] i_spi_oe,
   output logic [3:0] o_spi_in,
   output logic [port_mux_pkg::PORT_W-1:0] o_adc_chan_en,
   input wire logic [1:0] i_serial_port_zero_out,
   input wire logic [1:0] i_serial_port_zero_oe,
   output logic [1:0] o_serial_port_zero_in,
   output logic [1:0] o_ext_int_in,
   output logic [1:0] o_timers_in,
   input wire logic [1:0] i_i2c_out,
   input wire logic [1:0] i_i2c_oe,
   output logic [1:0] o_i2c_in,
   input wire logic [3:0] i_counter_array_zero_out,
   input wire logic [3:0] i_counter_array_zero_oe,
   output logic [3:0] o_counter_array_zero_in,
   input wire logic [3:0] i_counter_array_one_out,
   input wire logic [3:0] i_counter_array_one_oe,
   output logic [3:0] o_counter_array_one_in
);
   import port_mux_pkg::*;

   logic [7:0] p1_func_en;
   logic [7:0] p1_alt_sel;
   logic [7:0] p3_func_en;
   logic [7:0] p4_func_en;
   logic [7:0] p4_alt_sel;

   logic [23:0] pin_meta_reg;
   logic [23:0] pin_sync_reg;
   logic [7:0] p1_sync;
   logic [7:0] p3_sync;
   logic [7:0] p4_sync;

   pin_mode_t p1_mode [PORT_W];
   pin_mode_t p3_mode [PORT_W];
   pin_mode_t p4_mode [PORT_W];

   logic [7:0] p1_alt1_on;
   logic [7:0] p1_alt2_on;
   logic [7:0] p3_alt1_on;
   logic [7:0] p4_alt1_on;
   logic [7:0] p4_alt2_on;

   logic [7:0] shared_out;
   logic [7:0] shared_oe;
   logic [7:0] shared_in;
   logic [7:0] p3_alt_out;
   logic [7:0] p3_alt_oe;
   logic [7:0] p3_alt_in;
   logic [7:0] p4_alt_out;
   logic [7:0] p4_alt_oe;
   logic [7:0] p4_alt_in;

   logic [7:0] p1_pin_next;
   logic [7:0] p1_oe_next;
   logic [7:0] p3_pin_next;
   logic [7:0] p3_oe_next;
   logic [7:0] p4_pin_next;
   logic [7:0] p4_oe_next;

   port_select_regs u_regs (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_clk_en(i_clk_en),
      .i_sfr_addr(i_sfr_addr),
      .i_sfr_wr(i_sfr_wr),
      .i_sfr_rd(i_sfr_rd),
      .i_sfr_wdata(i_sfr_wdata),
      .o_sfr_rdata(o_sfr_rdata),
      .o_sfr_ack(o_sfr_ack),
      .o_p1_func_en(p1_func_en),
      .o_p1_alt_sel(p1_alt_sel),
      .o_p3_func_en(p3_func_en),
      .o_p4_func_en(p4_func_en),
      .o_p4_alt_sel(p4_alt_sel)
   );

   // Two-stage synchroniser for all pin inputs
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         pin_meta_reg <= 24'h000000;
         pin_sync_reg <= 24'h000000;
      end else if (i_clk_en) begin
         pin_meta_reg <= {i_p4_pin, i_p3_pin, i_p1_pin};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   assign p1_sync = pin_sync_reg[7:0];
   assign p3_sync = pin_sync_reg[15:8];
   assign p4_sync = pin_sync_reg[23:16];

   // Alternate function buses as seen by each port
   assign shared_out = {i_spi_out, i_serial_port_one_out, i_timer2_out};
   assign shared_oe = {i_spi_oe, i_serial_port_one_oe, i_timer2_oe};
   assign p3_alt_out = {i_i2c_out, 4'h0, i_serial_port_zero_out};
   assign p3_alt_oe = {i_i2c_oe, 4'h0, i_serial_port_zero_oe};
   assign p4_alt_out = {i_counter_array_one_out, i_counter_array_zero_out};
   assign p4_alt_oe = {i_counter_array_one_oe, i_counter_array_zero_oe};

   // Per-pin mode decode and output routing
   for (genvar i = 0; i < PORT_W; i++) begin : g_pin
      pin_mode_t p4_raw;

      assign p1_mode[i] = pin_mode(p1_func_en[i], p1_alt_sel[i],
                                   1'b1);
      assign p3_mode[i] = pin_mode(p3_func_en[i], 1'b0, 1'b0);
      assign p4_raw = pin_mode(p4_func_en[i], p4_alt_sel[i], 1'b1);

      // A function claimed by port 1 leaves the port 4 pin as GPIO
      assign p4_mode[i] = (p4_raw == MODE_ALT2 && p1_mode[i] == MODE_ALT1)
         ? MODE_GPIO : p4_raw;

      assign p1_alt1_on[i] = (p1_mode[i] == MODE_ALT1);
      assign p1_alt2_on[i] = (p1_mode[i] == MODE_ALT2);
      assign p3_alt1_on[i] = (p3_mode[i] == MODE_ALT1);
      assign p4_alt1_on[i] = (p4_mode[i] == MODE_ALT1);
      assign p4_alt2_on[i] = (p4_mode[i] == MODE_ALT2);

      // ADC inputs are analog: the digital driver stays off
      assign p1_pin_next[i] = route(p1_mode[i], i_gpio1_out[i],
                                    shared_out[i], 1'b0);
      assign p1_oe_next[i] = route(p1_mode[i], i_gpio1_oe[i],
                                   shared_oe[i], 1'b0);
      assign p3_pin_next[i] = route(p3_mode[i], i_gpio3_out[i],
                                    p3_alt_out[i], 1'b0);
      assign p3_oe_next[i] = route(p3_mode[i], i_gpio3_oe[i],
                                   p3_alt_oe[i], 1'b0);
      assign p4_pin_next[i] = route(p4_mode[i], i_gpio4_out[i],
                                    p4_alt_out[i], shared_out[i]);
      assign p4_oe_next[i] = route(p4_mode[i], i_gpio4_oe[i],
                                   p4_alt_oe[i], shared_oe[i]);
   end

   // Inputs returned to the shared peripherals, idle high when unmapped
   assign shared_in = (p1_alt1_on & p1_sync) | (p4_alt2_on & p4_sync)
      | ~(p1_alt1_on | p4_alt2_on);
   assign p3_alt_in = (p3_alt1_on & p3_sync) | ~p3_alt1_on;
   assign p4_alt_in = (p4_alt1_on & p4_sync) | ~p4_alt1_on;

   // Pin drivers
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_p1_pin <= 8'h00;
         o_p1_pin_oe <= 8'h00;
         o_p3_pin <= 8'h00;
         o_p3_pin_oe <= 8'h00;
         o_p4_pin <= 8'h00;
         o_p4_pin_oe <= 8'h00;
      end else if (i_clk_en) begin
         o_p1_pin <= p1_pin_next;
         o_p1_pin_oe <= p1_oe_next;
         o_p3_pin <= p3_pin_next;
         o_p3_pin_oe <= p3_oe_next;
         o_p4_pin <= p4_pin_next;
         o_p4_pin_oe <= p4_oe_next;
      end
   end

   // GPIO read values, zero while a pin serves a peripheral
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_gpio1_in <= 8'h00;
         o_gpio3_in <= 8'h00;
         o_gpio4_in <= 8'h00;
      end else if (i_clk_en) begin
         o_gpio1_in <= p1_sync & ~(p1_alt1_on | p1_alt2_on);
         o_gpio3_in <= p3_sync & ~p3_alt1_on;
         o_gpio4_in <= p4_sync & ~(p4_alt1_on | p4_alt2_on);
      end
   end

   // Peripheral inputs
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_timer2_in <= 2'h3;
         o_serial_port_one_in <= 2'h3;
         o_spi_in <= 4'hF;
         o_adc_chan_en <= 8'h00;
         o_serial_port_zero_in <= 2'h3;
         o_ext_int_in <= 2'h3;
         o_timers_in <= 2'h3;
         o_i2c_in <= 2'h3;
         o_counter_array_zero_in <= 4'hF;
         o_counter_array_one_in <= 4'hF;
      end else if (i_clk_en) begin
         o_timer2_in <= shared_in[TIMER2_LSB +: 2];
         o_serial_port_one_in <= shared_in[SERIAL_ONE_LSB +: 2];
         o_spi_in <= shared_in[SPI_LSB +: 4];
         o_adc_chan_en <= p1_alt2_on;
         o_serial_port_zero_in <= p3_alt_in[SERIAL_ZERO_LSB +: 2];
         o_ext_int_in <= p3_alt_in[EXT_INT_LSB +: 2];
         o_timers_in <= p3_alt_in[TIMERS_LSB +: 2];
         o_i2c_in <= p3_alt_in[I2C_LSB +: 2];
         o_counter_array_zero_in <= p4_alt_in[COUNTER_ZERO_LSB +: 4];
         o_counter_array_one_in <= p4_alt_in[COUNTER_ONE_LSB +: 4];
      end
   end

   sequence reset_release;
      i_rst ##1 (!i_rst && i_clk_en);
   endsequence

   sequence both_claim_bit2;
      i_clk_en && p1_func_en[2] && !p1_alt_sel[2]
         && p4_func_en[2] && p4_alt_sel[2];
   endsequence

   chk_p1_gpio_route: assert property (@(posedge i_clock)
      disable iff (i_rst)
      (i_clk_en && !p1_func_en[0]) |=> (o_p1_pin[0] == $past(i_gpio1_out[0]))
         && (o_p1_pin_oe[0] == $past(i_gpio1_oe[0])))
      else $error("Port 1 GPIO pin not routed");

   chk_p1_alt2_select: assert property (@(posedge i_clock)
      disable iff (i_rst)
      (i_clk_en && p1_func_en[5] && p1_alt_sel[5])
      |=> !o_p1_pin_oe[5] && o_adc_chan_en[5])
      else $error("Port 1 second alternate not selected");

   chk_p1_spi_map: assert property (@(posedge i_clock)
      disable iff (i_rst)
      (i_clk_en && p1_func_en[4] && !p1_alt_sel[4])
      |=> (o_p1_pin[4] == $past(i_spi_out[0]))
         && (o_p1_pin_oe[4] == $past(i_spi_oe[0])))
      else $error("SPI not on port 1 pin 4");

   chk_p3_i2c_map: assert property (@(posedge i_clock)
      disable iff (i_rst)
      (i_clk_en && p3_func_en[6])
      |=> (o_p3_pin[6] == $past(i_i2c_out[0]))
         && (o_p3_pin_oe[6] == $past(i_i2c_oe[0])))
      else $error("I2C not on port 3 pin 6");

   chk_p4_counter_map: assert property (@(posedge i_clock)
      disable iff (i_rst)
      (i_clk_en && p4_func_en[1] && !p4_alt_sel[1])
      |=> o_p4_pin[1] == $past(i_counter_array_zero_out[1]))
      else $error("Counter array zero not on port 4 pin 1");

   chk_p4_alt2_map: assert property (@(posedge i_clock)
      disable iff (i_rst)
      (i_clk_en && p4_func_en[7] && p4_alt_sel[7] && !p1_func_en[7])
      |=> (o_p4_pin[7] == $past(i_spi_out[3]))
         && (o_p4_pin_oe[7] == $past(i_spi_oe[3])))
      else $error("SPI not on port 4 pin 7");

   chk_port1_priority: assert property (@(posedge i_clock)
      disable iff (i_rst)
      both_claim_bit2 |=> (o_p4_pin_oe[2] == $past(i_gpio4_oe[2]))
         && (o_p1_pin_oe[2] == $past(i_serial_port_one_oe[0]))
         && (o_p4_pin[2] == $past(i_gpio4_out[2]))
         && (o_serial_port_one_in[0] == $past(p1_sync[2])))
      else $error("Port 4 kept a function claimed by port 1");

   chk_gpio_after_reset: assert property (@(posedge i_clock)
      reset_release |=> (o_p3_pin_oe == $past(i_gpio3_oe))
         && (o_p4_pin == $past(i_gpio4_out)))
      else $error("Pins not GPIO after reset");

endmodule

// ==== design/port_select_regs.sv ====
module port_select_regs
   import port_mux_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_clk_en,
   input wire logic [7:0] i_sfr_addr,
   input wire logic i_sfr_wr,
   input wire logic i_sfr_rd,
   input wire logic [7:0] i_sfr_wdata,
   output logic [7:0] o_sfr_rdata,
   output logic o_sfr_ack,
   output logic [7:0] o_p1_func_en,
   output logic [7:0] o_p1_alt_sel,
   output logic [7:0] o_p3_func_en,
   output logic [7:0] o_p4_func_en,
   output logic [7:0] o_p4_alt_sel
);
   import port_mux_pkg::*;

   logic [2:0] wr_slot;
   logic [2:0] rd_slot;

   assign wr_slot = reg_slot(i_sfr_addr);
   assign rd_slot = reg_slot(i_sfr_addr);

   // Select register writes
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_p1_func_en <= SEL_RESET;
         o_p1_alt_sel <= SEL_RESET;
         o_p3_func_en <= SEL_RESET;
         o_p4_func_en <= SEL_RESET;
         o_p4_alt_sel <= SEL_RESET;
      end else if (i_clk_en && i_sfr_wr) begin
         case (wr_slot)
            SLOT_P1_FUNC_EN: o_p1_func_en <= i_sfr_wdata;
            SLOT_P1_ALT_SEL: o_p1_alt_sel <= i_sfr_wdata;
            SLOT_P3_FUNC_EN: o_p3_func_en <= i_sfr_wdata;
            SLOT_P4_FUNC_EN: o_p4_func_en <= i_sfr_wdata;
            SLOT_P4_ALT_SEL: o_p4_alt_sel <= i_sfr_wdata;
            default: ;
         endcase
      end
   end

   // Read back, one cycle after the strobe
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_sfr_rdata <= UNMAPPED_READ;
         o_sfr_ack <= 1'b0;
      end else if (i_clk_en) begin
         o_sfr_ack <= i_sfr_rd && (rd_slot != SLOT_NONE);
         if (i_sfr_rd) begin
            case (rd_slot)
               SLOT_P1_FUNC_EN: o_sfr_rdata <= o_p1_func_en;
               SLOT_P1_ALT_SEL: o_sfr_rdata <= o_p1_alt_sel;
               SLOT_P3_FUNC_EN: o_sfr_rdata <= o_p3_func_en;
               SLOT_P4_FUNC_EN: o_sfr_rdata <= o_p4_func_en;
               SLOT_P4_ALT_SEL: o_sfr_rdata <= o_p4_alt_sel;
               default: o_sfr_rdata <= UNMAPPED_READ;
            endcase
         end
      end
   end

   sequence reset_pulse;
      i_rst;
   endsequence

   sequence p3_write;
      i_clk_en && i_sfr_wr && (i_sfr_addr == ADDR_P3_FUNC_EN);
   endsequence

   chk_reset_clears_all: assert property (@(posedge i_clock)
      reset_pulse |=> (o_p1_func_en == 8'h00) && (o_p1_alt_sel == 8'h00)
         && (o_p3_func_en == 8'h00) && (o_p4_func_en == 8'h00)
         && (o_p4_alt_sel == 8'h00))
      else $error("Select registers not cleared by reset");

   chk_write_takes_effect: assert property (@(posedge i_clock)
      disable iff (i_rst)
      p3_write |=> (o_p3_func_en == $past(i_sfr_wdata)))
      else $error("Port 3 select write not stored");

   chk_read_returns_reg: assert property (@(posedge i_clock)
      disable iff (i_rst)
      (i_clk_en && i_sfr_rd && !i_sfr_wr
         && (i_sfr_addr == ADDR_P4_ALT_SEL))
      |=> o_sfr_ack && (o_sfr_rdata == o_p4_alt_sel))
      else $error("Port 4 alternate select read back wrong");

endmodule

// ==== test/pin_pads.sv ====
module pin_pads (
   input wire logic [7:0] i_drive,
   input wire logic [7:0] i_drive_oe,
   input wire logic [7:0] i_ext,
   input wire logic [7:0] i_ext_oe,
   output logic [7:0] o_level
);
   timeunit 1ns;
   timeprecision 1ps;
   // Wire level of a bidirectional pin with pull-up when nobody drives
   assign o_level = (i_drive_oe & i_drive)
      | (~i_drive_oe & i_ext_oe & i_ext)
      | (~i_drive_oe & ~i_ext_oe);
endmodule

// ==== test/testbench.sv ====
`define CHK(g, e) chk(8'(g), 8'(e))
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import port_mux_pkg::*;
   logic i_clock = 1'b0, i_rst = 1'b1, i_clk_en = 1'b1;
   logic i_sfr_wr = 1'b0, i_sfr_rd = 1'b0, o_sfr_ack;
   logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, o_sfr_rdata;
   logic [7:0] i_p1_pin, o_p1_pin, o_p1_pin_oe, i_p3_pin, o_p3_pin;
   logic [7:0] o_p3_pin_oe, i_p4_pin, o_p4_pin, o_p4_pin_oe, o_adc_chan_en;
   logic [7:0] o_gpio1_in, o_gpio3_in, o_gpio4_in;
   logic [7:0] i_gpio1_out = 8'h00, i_gpio1_oe = 8'h00, i_gpio3_out = 8'h00;
   logic [7:0] i_gpio3_oe = 8'h00, i_gpio4_out = 8'h00, i_gpio4_oe = 8'h00;
   logic [7:0] ext1 = 8'h00, ext1_oe = 8'h00, ext3 = 8'h00, ext3_oe = 8'h00;
   logic [7:0] ext4 = 8'h00, ext4_oe = 8'h00;
   logic [1:0] i_timer2_out = 2'b00, i_timer2_oe = 2'b00, o_timer2_in;
   logic [1:0] i_serial_port_one_out = 2'b00, i_serial_port_one_oe = 2'b00;
   logic [1:0] i_serial_port_zero_out = 2'b00, i_serial_port_zero_oe = 2'b00;
   logic [1:0] i_i2c_out = 2'b00, i_i2c_oe = 2'b00, o_i2c_in;
   logic [1:0] o_serial_port_one_in, o_serial_port_zero_in, o_ext_int_in;
   logic [1:0] o_timers_in;
   logic [3:0] i_spi_out = 4'h0, i_spi_oe = 4'h0, o_spi_in;
   logic [3:0] i_counter_array_zero_out = 4'h0, i_counter_array_zero_oe = 4'h0;
   logic [3:0] i_counter_array_one_out = 4'h0, i_counter_array_one_oe = 4'h0;
   logic [3:0] o_counter_array_zero_in, o_counter_array_one_in;
   logic [7:0] addrs [5];
   int err_total = 0;
   int cmp_count = 0;

   mcu_port_function_mux mcu_port_function_mux_i (.i_clock, .i_rst,
      .i_clk_en, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata,
      .o_sfr_rdata, .o_sfr_ack, .i_p1_pin, .o_p1_pin, .o_p1_pin_oe,
      .i_p3_pin, .o_p3_pin, .o_p3_pin_oe, .i_p4_pin, .o_p4_pin, .o_p4_pin_oe,
      .i_gpio1_out, .i_gpio1_oe, .o_gpio1_in, .i_gpio3_out, .i_gpio3_oe,
      .o_gpio3_in, .i_gpio4_out, .i_gpio4_oe, .o_gpio4_in, .i_timer2_out,
      .i_timer2_oe, .o_timer2_in, .i_serial_port_one_out,
      .i_serial_port_one_oe, .o_serial_port_one_in, .i_spi_out, .i_spi_oe,
      .o_spi_in, .o_adc_chan_en, .i_serial_port_zero_out,
      .i_serial_port_zero_oe, .o_serial_port_zero_in, .o_ext_int_in,
      .o_timers_in, .i_i2c_out, .i_i2c_oe, .o_i2c_in,
      .i_counter_array_zero_out, .i_counter_array_zero_oe,
      .o_counter_array_zero_in, .i_counter_array_one_out,
      .i_counter_array_one_oe, .o_counter_array_one_in);
   pin_pads pin_pads_1_i (.i_drive(o_p1_pin), .i_drive_oe(o_p1_pin_oe),
      .i_ext(ext1), .i_ext_oe(ext1_oe), .o_level(i_p1_pin));
   pin_pads pin_pads_3_i (.i_drive(o_p3_pin), .i_drive_oe(o_p3_pin_oe),
      .i_ext(ext3), .i_ext_oe(ext3_oe), .o_level(i_p3_pin));
   pin_pads pin_pads_4_i (.i_drive(o_p4_pin), .i_drive_oe(o_p4_pin_oe),
      .i_ext(ext4), .i_ext_oe(ext4_oe), .o_level(i_p4_pin));

   always #10 i_clock = ~i_clock;

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic give_verdict();
      $display("Mismatches %0d, comparisons %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock);
      i_sfr_addr <= a;
      i_sfr_wdata <= d;
      i_sfr_wr <= 1'b1;
      @(posedge i_clock);
      i_sfr_wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp,
                         input logic exp_ack);
      @(posedge i_clock);
      i_sfr_addr <= a;
      i_sfr_rd <= 1'b1;
      @(posedge i_clock);
      i_sfr_rd <= 1'b0;
      #1;
      `CHK(o_sfr_rdata, exp);
      `CHK(o_sfr_ack, exp_ack);
   endtask

   task automatic settle();
      repeat (5) @(posedge i_clock);
      #1;
   endtask

   task automatic t_reset();
      foreach (addrs[k]) rd_chk(addrs[k], 8'h00, 1'b1);
      rd_chk(8'h90, UNMAPPED_READ, 1'b0);
      @(posedge i_clock);
      i_gpio1_out <= 8'hA5;
      i_gpio1_oe <= 8'hFF;
      i_gpio3_oe <= 8'hFF;
      i_gpio4_out <= 8'h3C;
      i_gpio4_oe <= 8'hF0;
      settle();
      `CHK(o_p1_pin, 8'hA5);
      `CHK(o_p1_pin_oe, 8'hFF);
      `CHK(o_p3_pin_oe, 8'hFF);
      `CHK(o_p4_pin_oe, 8'hF0);
      `CHK(o_p4_pin & o_p4_pin_oe, 8'h30);
   endtask

   task automatic t_regs();
      foreach (addrs[k]) wr_reg(addrs[k], 8'(8'h11 * (k + 1)));
      foreach (addrs[k]) begin
         rd_chk(addrs[k], 8'(8'h11 * (k + 1)), 1'b1);
      end
      @(posedge i_clock);
      i_clk_en <= 1'b0;
      wr_reg(ADDR_P3_FUNC_EN, 8'hEE);
      i_clk_en <= 1'b1;
      rd_chk(ADDR_P3_FUNC_EN, 8'h33, 1'b1);
      foreach (addrs[k]) wr_reg(addrs[k], 8'h00);
   endtask

   task automatic t_port1();
      i_timer2_out <= 2'b10;
      i_timer2_oe <= 2'b11;
      i_serial_port_one_out <= 2'b01;
      i_serial_port_one_oe <= 2'b10;
      i_spi_oe <= 4'h0;
      ext1 <= 8'h5F;
      ext1_oe <= 8'hF0;
      wr_reg(ADDR_P1_FUNC_EN, 8'hFF);
      settle();
      `CHK(o_p1_pin_oe, 8'h0B);
      `CHK(o_p1_pin & o_p1_pin_oe, 8'h02);
      `CHK(o_spi_in, 4'h5);
      `CHK(o_timer2_in, 2'b10);
      `CHK(o_serial_port_one_in, 2'b01);
      `CHK(o_gpio1_in, 8'h00);
      wr_reg(ADDR_P1_ALT_SEL, 8'hFF);
      settle();
      `CHK(o_adc_chan_en, 8'hFF);
      `CHK(o_p1_pin_oe, 8'h00);
      `CHK(o_timer2_in, 2'b11);
      wr_reg(ADDR_P1_ALT_SEL, 8'h00);
      wr_reg(ADDR_P1_FUNC_EN, 8'hF0);
      i_spi_out <= 4'h6;
      i_spi_oe <= 4'hF;
      ext1_oe <= 8'h00;
      settle();
      `CHK(o_p1_pin_oe, 8'hFF);
      `CHK(o_p1_pin, 8'h65);
      `CHK(o_adc_chan_en, 8'h00);
      wr_reg(ADDR_P1_FUNC_EN, 8'h00);
   endtask

   task automatic t_port3();
      i_serial_port_zero_out <= 2'b10;
      i_serial_port_zero_oe <= 2'b11;
      i_i2c_out <= 2'b01;
      i_i2c_oe <= 2'b11;
      ext3 <= 8'h14;
      ext3_oe <= 8'h3C;
      wr_reg(ADDR_P3_FUNC_EN, 8'hFF);
      settle();
      `CHK(o_p3_pin_oe, 8'hC3);
      `CHK(o_p3_pin & o_p3_pin_oe, 8'h42);
      `CHK(o_serial_port_zero_in, 2'b10);
      `CHK(o_ext_int_in, 2'b01);
      `CHK(o_timers_in, 2'b01);
      `CHK(o_i2c_in, 2'b01);
      `CHK(o_gpio3_in, 8'h00);
      wr_reg(ADDR_P3_FUNC_EN, 8'h00);
   endtask

   task automatic t_port4();
      i_counter_array_zero_out <= 4'h3;
      i_counter_array_zero_oe <= 4'hF;
      i_counter_array_one_out <= 4'hC;
      i_counter_array_one_oe <= 4'hF;
      i_gpio4_out <= 8'h00;
      i_gpio4_oe <= 8'hFF;
      wr_reg(ADDR_P4_FUNC_EN, 8'hFF);
      settle();
      `CHK(o_p4_pin, 8'hC3);
      `CHK(o_counter_array_one_in, 4'hC);
      wr_reg(ADDR_P4_ALT_SEL, 8'hFF);
      settle();
      `CHK(o_p4_pin_oe, 8'hFB);
      `CHK(o_p4_pin & o_p4_pin_oe, 8'h62);
      `CHK(o_counter_array_zero_in, 4'hF);
      wr_reg(ADDR_P1_FUNC_EN, 8'h07);
      settle();
      `CHK(o_p1_pin[1:0], 2'b10);
      `CHK(o_p4_pin_oe, 8'hFF);
      `CHK(o_p4_pin & o_p4_pin_oe, 8'h60);
      `CHK(o_serial_port_one_in, 2'b01);
      wr_reg(ADDR_P1_FUNC_EN, 8'h00);
      wr_reg(ADDR_P4_FUNC_EN, 8'h00);
   endtask

   task automatic t_gpio();
      i_gpio1_out <= 8'h05;
      i_gpio1_oe <= 8'h0F;
      i_gpio4_oe <= 8'h00;
      ext1 <= 8'hA0;
      ext1_oe <= 8'hF0;
      settle();
      `CHK(o_p1_pin_oe, 8'h0F);
      `CHK(o_gpio1_in, 8'hA5);
      `CHK(o_gpio4_in, 8'hFF);
   endtask

   initial begin
      #60000;
      err_total++;
      give_verdict();
   end

   initial begin
      addrs = '{ADDR_P1_FUNC_EN, ADDR_P1_ALT_SEL, ADDR_P3_FUNC_EN,
                ADDR_P4_FUNC_EN, ADDR_P4_ALT_SEL};
      repeat (5) @(posedge i_clock);
      i_rst <= 1'b0;
      t_reset();
      t_regs();
      t_port1();
      t_port3();
      t_port4();
      t_gpio();
      give_verdict();
   end
endmodule
